//--- common/blc_consts.svh
// Register select codes, status bit positions, reset values and line constants
// for the link controller host port. Assumes inclusion by bare name.
`ifndef BLC_CONSTS_SVH
`define BLC_CONSTS_SVH
`define BLC_SEL_STATUS   2'h0
`define BLC_SEL_RESULT   2'h1
`define BLC_SEL_TXOUT    2'h2
`define BLC_SEL_RXOUT    2'h3
`define BLC_ST_BUSY      7
`define BLC_ST_PARAM     6
`define BLC_ST_RESULT    5
`define BLC_ST_TXO       4
`define BLC_ST_RXO       3
`define BLC_ST_TXFULL    2
`define BLC_ST_RXFULL    1
`define BLC_ST_ERR       0
`define BLC_SERIAL_RST   8'h01
`define BLC_MODE_RST     8'h00
`define BLC_PORTB_RST    4'hf
`define BLC_SER_NRZI     0
`define BLC_MODE_IRQ     0
`define BLC_FLAG         8'h7e
`define BLC_RES_OK       8'h00
`define BLC_RES_BADCMD   8'h01
`define BLC_RES_UNDERRUN 8'h02
`define BLC_RES_ABORT    8'h03
`define BLC_RES_OVERRUN  8'h04
`endif

//--- common/blc_pkg.sv
// Types for the link controller host port: command phases and opcodes.
// Assumes nothing of its surroundings.
package blc_pkg;
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_PARAM  = 2'b01,
    PH_EXEC   = 2'b10,
    PH_RESULT = 2'b11
  } blc_phase_t;
  typedef enum logic [7:0] {
    OP_GEN_RX      = 8'h01,
    OP_SEL_RX      = 8'h02,
    OP_SEL_LOOP_RX = 8'h03,
    OP_SEARCH_RX   = 8'h04,
    OP_RX_DISABLE  = 8'h05,
    OP_TX_FRAME    = 8'h06,
    OP_TX_LOOP     = 8'h07,
    OP_TX_TRANSP   = 8'h08,
    OP_ABORT_FRAME = 8'h09,
    OP_ABORT_LOOP  = 8'h0a,
    OP_ABORT_TRANS = 8'h0b,
    OP_READ_PA     = 8'h0c,
    OP_READ_PB     = 8'h0d,
    OP_SET_DELAY   = 8'h10,
    OP_CLR_DELAY   = 8'h11,
    OP_SET_SERIAL  = 8'h12,
    OP_CLR_SERIAL  = 8'h13,
    OP_SET_MODE    = 8'h14,
    OP_CLR_MODE    = 8'h15,
    OP_SET_PORTB   = 8'h16,
    OP_CLR_PORTB   = 8'h17
  } blc_op_t;
endpackage : blc_pkg

//--- hdl/blc_host_port.sv
// Host port, command sequencer and serial line logic of a bit-oriented link
// controller. Assumes a host on an 8-bit strobed bus and a modem on the line.
`timescale 1ns/10ps
`include "blc_consts.svh"

module blc_sync3 #(
  parameter int           W  = 1,
  parameter logic [W-1:0] RV = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1Q, s2Q, s3Q;
  if (W < 1) begin : g_chk
    $error("blc_sync3 width must be positive");
  end
  // Each bit changes only once the second and third stage agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1Q <= RV;
      s2Q <= RV;
      s3Q <= RV;
      q   <= RV;
    end else begin
      s1Q <= d;
      s2Q <= s1Q;
      s3Q <= s2Q;
      q   <= (s3Q & ~(s2Q ^ s3Q)) | (q & (s2Q ^ s3Q));
    end
  end
endmodule : blc_sync3

module blc_host_port #(
  parameter int MAX_PARAMS = 4,
  parameter int PLL_RATIO  = 32
) (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       oversampleClock,
  input  wire logic       chipSelN,
  input  wire logic       readN,
  input  wire logic       writeN,
  input  wire logic [1:0] regSelect,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe,
  output logic            sendServiceIrq,
  output logic            recvServiceIrq,
  output logic            sendDmaReq,
  output logic            recvDmaReq,
  input  wire logic       sendDmaGrantN,
  input  wire logic       recvDmaGrantN,
  input  wire logic       sendBitClock,
  input  wire logic       recvBitClock,
  input  wire logic       recvData,
  output logic            sendData,
  output logic            recoveredClockOut,
  output logic            frameMarkerSeen,
  output logic            reqToSendN,
  input  wire logic       clearToSend,
  input  wire logic       carrierPresentIn,
  input  wire logic [2:0] gpInputs,
  output logic      [3:0] gpOutputs
);
  localparam int PH_W = $clog2(PLL_RATIO);
  if (MAX_PARAMS != 4 || PLL_RATIO != 32) begin : g_chk
    $error("blc_host_port supports four parameters and a 32x loop only");
  end

  // Pin synchronisers; strobes idle high so reset cannot fake an edge
  logic       csS, rdS, wrS, sgS, rgS, txcS, rxcS, ctsS, cdS, rxdS, rxdL;
  logic [1:0] selS;
  logic [7:0] dinS;
  logic [2:0] gpiS;
  blc_sync3 #(.W(7), .RV(7'h7c)) uBus (
    .clk(ref_clk), .rst(sys_rst),
    .d({chipSelN, readN, writeN, sendDmaGrantN, recvDmaGrantN, regSelect}),
    .q({csS, rdS, wrS, sgS, rgS, selS}));
  blc_sync3 #(.W(8), .RV(8'h00)) uData (
    .clk(ref_clk), .rst(sys_rst), .d(dataIn), .q(dinS));
  blc_sync3 #(.W(8), .RV(8'h00)) uLine (
    .clk(ref_clk), .rst(sys_rst),
    .d({sendBitClock, recvBitClock, clearToSend, carrierPresentIn, recvData, gpInputs}),
    .q({txcS, rxcS, ctsS, cdS, rxdS, gpiS}));
  blc_sync3 #(.W(1), .RV(1'b0)) uPllIn (
    .clk(oversampleClock), .rst(sys_rst), .d(recvData), .q(rxdL));

  logic rdPrevQ, wrPrevQ, txcPrevQ, rxcPrevQ;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdPrevQ  <= 1'b1;
      wrPrevQ  <= 1'b1;
      txcPrevQ <= 1'b0;
      rxcPrevQ <= 1'b0;
    end else begin
      rdPrevQ  <= rdS;
      wrPrevQ  <= wrS;
      txcPrevQ <= txcS;
      rxcPrevQ <= rxcS;
    end
  end
  wire logic rdFall  = rdPrevQ & ~rdS;
  wire logic wrFall  = wrPrevQ & ~wrS;
  wire logic hostWr  = wrFall & ~csS;
  wire logic hostRd  = rdFall & ~csS;
  wire logic dmaTxWr = wrFall & ~sgS & csS;
  wire logic dmaRxRd = rdFall & ~rgS & csS;
  wire logic txShift = txcPrevQ & ~txcS;
  wire logic rxSample = ~rxcPrevQ & rxcS & cdS;

  blc_pkg::blc_phase_t phaseQ;
  logic [7:0] opQ, p0Q, resultQ, txOutQ, rxOutQ;
  logic [2:0] needQ, cntQ;
  logic       resAvailQ, txoAvailQ, rxoAvailQ, errQ, startQ;
  logic [7:0] serialQ, modeQ;
  logic       delayQ, txFullQ, rxFullQ, txDoneQ, txUnderQ, rxEndQ, rxOverQ;
  logic [3:0] gpOutQ;

  function automatic logic [3:0] opInfo(input logic [7:0] c);
    // Returns known flag and parameter count
    opInfo = 4'h0;
    unique case (c)
      blc_pkg::OP_GEN_RX, blc_pkg::OP_SEARCH_RX, blc_pkg::OP_RX_DISABLE,
      blc_pkg::OP_ABORT_FRAME, blc_pkg::OP_ABORT_LOOP, blc_pkg::OP_ABORT_TRANS,
      blc_pkg::OP_READ_PA, blc_pkg::OP_READ_PB, blc_pkg::OP_SET_DELAY,
      blc_pkg::OP_CLR_DELAY: opInfo = 4'h8;
      blc_pkg::OP_SEL_RX: opInfo = 4'ha;
      blc_pkg::OP_SEL_LOOP_RX: opInfo = 4'hc;
      blc_pkg::OP_TX_FRAME, blc_pkg::OP_TX_LOOP, blc_pkg::OP_TX_TRANSP,
      blc_pkg::OP_SET_SERIAL, blc_pkg::OP_CLR_SERIAL, blc_pkg::OP_SET_MODE,
      blc_pkg::OP_CLR_MODE, blc_pkg::OP_SET_PORTB, blc_pkg::OP_CLR_PORTB: opInfo = 4'h9;
      default: opInfo = 4'h0;
    endcase
  endfunction : opInfo

  wire logic isTxOp = opQ >= blc_pkg::OP_TX_FRAME && opQ <= blc_pkg::OP_TX_TRANSP;
  wire logic isRxOp = opQ >= blc_pkg::OP_GEN_RX && opQ <= blc_pkg::OP_SEARCH_RX;
  wire logic inExec = phaseQ == blc_pkg::PH_EXEC;
  wire logic txRun  = inExec & isTxOp & ~startQ;
  wire logic rxRun  = inExec & isRxOp & ~startQ;
  wire logic immRun = inExec & ~isTxOp & ~isRxOp;
  wire logic stopCmd = hostWr && selS == `BLC_SEL_STATUS &&
                       ((dinS >= blc_pkg::OP_ABORT_FRAME && dinS <= blc_pkg::OP_ABORT_TRANS)
                        || dinS == blc_pkg::OP_RX_DISABLE);
  wire logic [3:0] newInfo = opInfo(dinS);
  wire logic [3:0] curInfo = opInfo(opQ);
  logic [7:0] rxBytesQ;

  // Command, execution and result sequencing
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phaseQ    <= blc_pkg::PH_IDLE;
      opQ       <= 8'h00;
      p0Q       <= 8'h00;
      needQ     <= 3'h0;
      cntQ      <= 3'h0;
      startQ    <= 1'b0;
      resultQ   <= 8'h00;
      txOutQ    <= 8'h00;
      rxOutQ    <= 8'h00;
      resAvailQ <= 1'b0;
      txoAvailQ <= 1'b0;
      rxoAvailQ <= 1'b0;
      errQ      <= 1'b0;
    end else begin
      startQ <= 1'b0;
      if (hostRd && selS == `BLC_SEL_TXOUT) txoAvailQ <= 1'b0;
      if (hostRd && selS == `BLC_SEL_RXOUT) rxoAvailQ <= 1'b0;
      unique case (phaseQ)
        blc_pkg::PH_IDLE: if (hostWr && selS == `BLC_SEL_STATUS) begin
          opQ   <= dinS;
          needQ <= newInfo[2:0];
          cntQ  <= 3'h0;
          errQ  <= 1'b0;
          if (newInfo[2:0] == 3'h0) begin
            phaseQ <= blc_pkg::PH_EXEC;
            startQ <= 1'b1;
          end else begin
            phaseQ <= blc_pkg::PH_PARAM;
          end
        end
        blc_pkg::PH_PARAM: if (hostWr && selS == `BLC_SEL_RESULT) begin
          if (cntQ == 3'h0) p0Q <= dinS;
          cntQ <= cntQ + 3'h1;
          if (cntQ + 3'h1 == needQ) begin
            phaseQ <= blc_pkg::PH_EXEC;
            startQ <= 1'b1;
          end
        end
        blc_pkg::PH_EXEC: begin
          if (immRun) begin
            phaseQ    <= blc_pkg::PH_RESULT;
            resAvailQ <= 1'b1;
            errQ      <= ~curInfo[3];
            if (opQ == blc_pkg::OP_READ_PA) resultQ <= {5'h00, gpiS};
            else if (opQ == blc_pkg::OP_READ_PB) resultQ <= {4'h0, gpOutQ};
            else resultQ <= curInfo[3] ? `BLC_RES_OK : `BLC_RES_BADCMD;
          end else if (stopCmd) begin
            phaseQ    <= blc_pkg::PH_RESULT;
            resAvailQ <= 1'b1;
            resultQ   <= `BLC_RES_ABORT;
            if (isTxOp) begin
              txOutQ    <= `BLC_RES_ABORT;
              txoAvailQ <= 1'b1;
            end else begin
              rxOutQ    <= rxBytesQ;
              rxoAvailQ <= 1'b1;
            end
          end else if (txDoneQ || txUnderQ) begin
            phaseQ    <= blc_pkg::PH_RESULT;
            resAvailQ <= 1'b1;
            errQ      <= txUnderQ;
            resultQ   <= txUnderQ ? `BLC_RES_UNDERRUN : `BLC_RES_OK;
            txOutQ    <= txUnderQ ? `BLC_RES_UNDERRUN : `BLC_RES_OK;
            txoAvailQ <= 1'b1;
          end else if (rxEndQ || rxOverQ) begin
            phaseQ    <= blc_pkg::PH_RESULT;
            resAvailQ <= 1'b1;
            errQ      <= rxOverQ;
            resultQ   <= rxOverQ ? `BLC_RES_OVERRUN : `BLC_RES_OK;
            rxOutQ    <= rxBytesQ;
            rxoAvailQ <= 1'b1;
          end
        end
        blc_pkg::PH_RESULT: if (hostRd && selS == `BLC_SEL_RESULT) begin
          resAvailQ <= 1'b0;
          phaseQ    <= blc_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // Mode, serial and port registers written by immediate commands
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serialQ <= `BLC_SERIAL_RST;
      modeQ   <= `BLC_MODE_RST;
      delayQ  <= 1'b0;
      gpOutQ  <= `BLC_PORTB_RST;
    end else if (immRun) begin
      unique case (opQ)
        blc_pkg::OP_SET_DELAY:  delayQ  <= 1'b1;
        blc_pkg::OP_CLR_DELAY:  delayQ  <= 1'b0;
        blc_pkg::OP_SET_SERIAL: serialQ <= serialQ | p0Q;
        blc_pkg::OP_CLR_SERIAL: serialQ <= serialQ & ~p0Q;
        blc_pkg::OP_SET_MODE:   modeQ   <= modeQ | p0Q;
        blc_pkg::OP_CLR_MODE:   modeQ   <= modeQ & ~p0Q;
        blc_pkg::OP_SET_PORTB:  gpOutQ  <= gpOutQ | p0Q[3:0];
        blc_pkg::OP_CLR_PORTB:  gpOutQ  <= gpOutQ & ~p0Q[3:0];
        default: ;
      endcase
    end
  end
  wire logic nrziOn  = serialQ[`BLC_SER_NRZI];
  wire logic irqMode = modeQ[`BLC_MODE_IRQ];

  // Transmit path: one buffer byte ahead of the shifter
  logic [7:0] txBufQ, txShQ, txLeftQ;
  logic [2:0] txBitQ;
  logic       txLoadedQ, txdQ, delayBitQ;
  wire logic  txBit = txLoadedQ ? txShQ[0] : txBufQ[0];
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txBufQ <= 8'h00; txShQ <= 8'h00; txLeftQ <= 8'h00; txBitQ <= 3'h0;
      txLoadedQ <= 1'b0; txFullQ <= 1'b0; txdQ <= 1'b1;
      txDoneQ <= 1'b0; txUnderQ <= 1'b0;
    end else begin
      txDoneQ  <= 1'b0;
      txUnderQ <= 1'b0;
      if (startQ && isTxOp) begin
        txLeftQ   <= p0Q;
        txBitQ    <= 3'h0;
        txLoadedQ <= 1'b0;
        txFullQ   <= 1'b0;
      end else if (txRun && txShift && ctsS) begin
        if (!txLoadedQ && txLeftQ == 8'h00) begin
          txDoneQ <= 1'b1;
        end else if (!txLoadedQ && !txFullQ) begin
          txUnderQ <= 1'b1;
        end else begin
          txdQ <= nrziOn ? (txBit ? txdQ : ~txdQ) : txBit;
          if (!txLoadedQ) begin
            txShQ     <= {1'b0, txBufQ[7:1]};
            txFullQ   <= 1'b0;
            txLoadedQ <= 1'b1;
            txLeftQ   <= txLeftQ - 8'h01;
          end else begin
            txShQ <= {1'b0, txShQ[7:1]};
          end
          txBitQ <= txBitQ + 3'h1;
          if (txBitQ == 3'h7) txLoadedQ <= 1'b0;
        end
      end else if (!txRun && delayQ && rxSample) begin
        txdQ <= delayBitQ;  // Loop station repeats the line one bit late
      end
      if (dmaTxWr && txRun) begin  // Host write wins over the shifter's take
        txBufQ  <= dinS;
        txFullQ <= 1'b1;
      end
    end
  end

  // Receive path with NRZI decode, flag hunt and byte assembly
  logic [7:0] flagShQ, rxShQ, rxBufQ;
  logic [2:0] rxBitQ;
  logic       rxPrevQ, inFrameQ, markQ;
  wire logic       rxBit = nrziOn ? (rxdS == rxPrevQ) : rxdS;
  wire logic [7:0] flagD = {rxBit, flagShQ[7:1]};
  wire logic       flagHit = rxSample && flagD == `BLC_FLAG;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flagShQ <= 8'h00; rxShQ <= 8'h00; rxBufQ <= 8'h00; rxBitQ <= 3'h0;
      rxPrevQ <= 1'b1; inFrameQ <= 1'b0; markQ <= 1'b0; delayBitQ <= 1'b1;
      rxFullQ <= 1'b0; rxEndQ <= 1'b0; rxOverQ <= 1'b0; rxBytesQ <= 8'h00;
    end else begin
      markQ  <= flagHit;
      rxEndQ <= 1'b0;
      rxOverQ <= 1'b0;
      if (dmaRxRd) rxFullQ <= 1'b0;
      if (rxSample) begin
        rxPrevQ   <= rxdS;
        delayBitQ <= rxdS;
        flagShQ   <= flagD;
      end
      if (startQ && isRxOp) begin
        inFrameQ <= 1'b0;
        rxBytesQ <= 8'h00;
        rxFullQ  <= 1'b0;
      end else if (rxRun && flagHit) begin
        inFrameQ <= 1'b1;
        rxBitQ   <= 3'h0;
        if (rxBytesQ != 8'h00) rxEndQ <= 1'b1;
      end else if (rxRun && rxSample && inFrameQ) begin
        rxShQ  <= {rxBit, rxShQ[7:1]};
        rxBitQ <= rxBitQ + 3'h1;
        if (rxBitQ == 3'h7) begin
          rxBufQ   <= {rxBit, rxShQ[7:1]};
          rxFullQ  <= 1'b1;  // Set wins over a same-cycle DMA read
          rxBytesQ <= rxBytesQ + 8'h01;
          if (rxFullQ && !dmaRxRd) rxOverQ <= 1'b1;
        end
      end
    end
  end

  // Host read data, requests, interrupts and modem outputs
  wire logic [7:0] statusVal = {phaseQ != blc_pkg::PH_IDLE, phaseQ == blc_pkg::PH_PARAM,
                                resAvailQ, txoAvailQ, rxoAvailQ, txFullQ, rxFullQ, errQ};
  // No request once every counted byte is loaded: a byte taken then would never be sent
  wire logic txWant = txRun & ~txFullQ & (txLeftQ != 8'h00);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataOut <= 8'h00; dataOe <= 1'b0; sendDmaReq <= 1'b0; recvDmaReq <= 1'b0;
      sendServiceIrq <= 1'b0; recvServiceIrq <= 1'b0; reqToSendN <= 1'b1;
      sendData <= 1'b1; frameMarkerSeen <= 1'b1; gpOutputs <= `BLC_PORTB_RST;
    end else begin
      dataOe <= ~rdS & (~csS | ~rgS);
      if (~csS) begin
        unique case (selS)
          `BLC_SEL_STATUS: dataOut <= statusVal;
          `BLC_SEL_RESULT: dataOut <= resultQ;
          `BLC_SEL_TXOUT:  dataOut <= txOutQ;
          `BLC_SEL_RXOUT:  dataOut <= rxOutQ;
        endcase
      end else begin
        dataOut <= rxBufQ;
      end
      sendDmaReq     <= txWant & ~irqMode;
      recvDmaReq     <= rxRun & rxFullQ & ~irqMode;
      sendServiceIrq <= (txWant & irqMode) | txoAvailQ;
      recvServiceIrq <= (rxRun & rxFullQ & irqMode) | rxoAvailQ;
      reqToSendN     <= ~txRun;
      sendData       <= txdQ;
      frameMarkerSeen <= ~markQ;
      gpOutputs      <= gpOutQ;
    end
  end

  // Recovered bit clock: edges late in the cell pull the phase forward
  logic [PH_W-1:0] pllPhQ;
  logic            pllPrevQ;
  always_ff @(posedge oversampleClock or posedge sys_rst) begin
    if (sys_rst) begin
      pllPhQ <= '0; pllPrevQ <= 1'b0; recoveredClockOut <= 1'b1;
    end else begin
      pllPrevQ <= rxdL;
      if (rxdL != pllPrevQ && pllPhQ[PH_W-1]) pllPhQ <= pllPhQ + PH_W'(2);
      else if (rxdL != pllPrevQ) pllPhQ <= pllPhQ;
      else pllPhQ <= pllPhQ + PH_W'(1);
      recoveredClockOut <= pllPhQ[PH_W-1];
    end
  end

  sequence sLastParam;
    phaseQ == blc_pkg::PH_PARAM && hostWr && selS == `BLC_SEL_RESULT && cntQ + 3'h1 == needQ;
  endsequence
  sequence sEnterExec;
    phaseQ == blc_pkg::PH_EXEC && startQ;
  endsequence
  a_param_to_exec: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sLastParam |=> sEnterExec)
    else $error("last parameter did not start execution");
  a_imm_result: assert property (@(posedge ref_clk) disable iff (sys_rst)
    immRun |=> phaseQ == blc_pkg::PH_RESULT && resAvailQ)
    else $error("immediate command did not reach result");
  a_status_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ~csS && ~rdS && selS == `BLC_SEL_STATUS |=> dataOut == $past(statusVal) && dataOe)
    else $error("status read returned wrong value");
  a_flag_mark: assert property (@(posedge ref_clk) disable iff (sys_rst)
    flagHit |=> ##1 !frameMarkerSeen)
    else $error("flag not reported");
  a_carrier_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !cdS |=> $stable(flagShQ))
    else $error("sampled without carrier");
  a_nrzi_send: assert property (@(posedge ref_clk) disable iff (sys_rst)
    txRun && txShift && ctsS && (txLoadedQ || (txFullQ && txLeftQ != 8'h00)) && nrziOn
    |=> txdQ == ($past(txBit) ? $past(txdQ) : ~$past(txdQ)))
    else $error("transmit bit not NRZI encoded");
  a_rts_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
    txRun |=> !reqToSendN)
    else $error("request to send missing while transmitting");
  a_tx_dma: assert property (@(posedge ref_clk) disable iff (sys_rst)
    txWant && !irqMode |=> sendDmaReq)
    else $error("transmit request missing");
  a_port_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
    immRun && opQ == blc_pkg::OP_SET_PORTB |=> ##1 gpOutputs == ($past(gpOutQ, 2) | $past(p0Q[3:0], 2)))
    else $error("port bits not set");
  a_pll_step: assert property (@(posedge oversampleClock) disable iff (sys_rst)
    rxdL == pllPrevQ |=> pllPhQ == $past(pllPhQ) + PH_W'(1))
    else $error("loop phase did not advance");
endmodule : blc_host_port

//--- tb/bit_oriented_link_ctrl_host_port_tb.sv
// Self-checking bench for the link controller host port.
// Assumes the host model drives the bus; the bench plays the modem and line.
`timescale 1ns/10ps
`include "blc_consts.svh"
module bit_oriented_link_ctrl_host_port_tb;
  logic       ref_clk, sys_rst, oversampleClock, bitClk, recvData;
  logic       clearToSend, carrierPresentIn, seen;
  logic [2:0] gpInputs;
  logic [7:0] st, res, d;
  logic       chipSelN, readN, writeN, sendGntN, recvGntN, sendDmaReq, sendData;
  logic       recoveredClockOut, frameMarkerSeen, reqToSendN;
  logic       sendServiceIrq, recvServiceIrq, recvDmaReq, rxReq;
  logic [1:0] regSelect;
  logic [7:0] dataIn, dataOut;
  logic [3:0] gpOutputs;
  logic       q[$];
  int         fails, num_checks, cycles, rcv, txEdges;
  blc_host_port i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .oversampleClock(oversampleClock), .chipSelN(chipSelN), .readN(readN),
    .writeN(writeN), .regSelect(regSelect), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(), .sendServiceIrq(sendServiceIrq), .recvServiceIrq(recvServiceIrq),
    .sendDmaReq(sendDmaReq), .recvDmaReq(recvDmaReq), .sendDmaGrantN(sendGntN),
    .recvDmaGrantN(recvGntN),
    .sendBitClock(bitClk), .recvBitClock(bitClk), .recvData(recvData),
    .sendData(sendData), .recoveredClockOut(recoveredClockOut),
    .frameMarkerSeen(frameMarkerSeen), .reqToSendN(reqToSendN),
    .clearToSend(clearToSend), .carrierPresentIn(carrierPresentIn),
    .gpInputs(gpInputs), .gpOutputs(gpOutputs));
  blc_host_model i_host (.ref_clk(ref_clk), .dataOut(dataOut), .chipSelN(chipSelN),
    .readN(readN), .writeN(writeN), .sendDmaGrantN(sendGntN),
    .recvDmaGrantN(recvGntN), .regSelect(regSelect), .dataIn(dataIn));
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    oversampleClock = 0;
    #7;
    forever #24 oversampleClock = ~oversampleClock;
  end
  // Bit clock runs free; the line sender changes data at its fall
  initial begin
    bitClk = 1;
    forever begin
      repeat (8) @(negedge ref_clk);
      bitClk = ~bitClk;
    end
  end
  always @(negedge bitClk) if (q.size() != 0) if (q.pop_front() == 1'b0) recvData <= ~recvData;
  always @(posedge ref_clk) if (frameMarkerSeen === 1'b0) seen <= 1'b1;
  always @(posedge recoveredClockOut) rcv++;
  always @(posedge ref_clk) if (recvDmaReq === 1'b1) rxReq <= 1'b1;
  always @(sendData) txEdges++;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task automatic t_ports();
    chk({1'b0, reqToSendN, sendData, frameMarkerSeen, gpOutputs}, 8'h7f);
    i_host.cyc(1'b0, 1'b0, 2'h0, 8'h00, st);
    chk(st, 8'h00);
    i_host.issue(8'h17, 1, 8'h05);
    i_host.finish(st, res);
    chk(res, `BLC_RES_OK);
    chk({4'h0, gpOutputs}, 8'h0a);
    i_host.issue(8'h16, 1, 8'h0f);
    i_host.finish(st, res);
    chk({4'h0, gpOutputs}, 8'h0f);
    i_host.issue(8'h0d, 0, 8'h00);
    i_host.finish(st, res);
    chk(res, 8'h0f);
    gpInputs = 3'h5;
    i_host.issue(8'h0c, 0, 8'h00);
    i_host.finish(st, res);
    chk(res, 8'h05);
  endtask : t_ports
  task automatic t_phases();
    i_host.issue(8'hff, 0, 8'h00);
    i_host.finish(st, res);
    chk({7'h0, st[`BLC_ST_ERR]}, 8'h01);
    chk(res, `BLC_RES_BADCMD);
    i_host.issue(8'h14, 0, 8'h00);
    i_host.cyc(1'b0, 1'b0, 2'h0, 8'h00, st);
    chk(st & 8'hc0, 8'hc0);
    i_host.cyc(1'b1, 1'b0, 2'h1, 8'h00, d);
    i_host.finish(st, res);
    chk(res, `BLC_RES_OK);
  endtask : t_phases
  task automatic t_send();
    i_host.issue(8'h06, 1, 8'h01);
    for (int i = 0; i < 200 && sendDmaReq !== 1'b1; i++) @(negedge ref_clk);
    chk({7'h0, sendDmaReq}, 8'h01);
    chk({7'h0, reqToSendN}, 8'h00);
    i_host.cyc(1'b1, 1'b1, 2'h0, 8'h00, d);
    chk({7'h0, sendDmaReq}, 8'h00);
    txEdges = 0;
    // Modem clears only once the byte waits; the free bit clock would underrun otherwise
    clearToSend = 1'b1;
    i_host.finish(st, res);
    chk(res, `BLC_RES_OK);
    chk({7'h0, sendServiceIrq}, 8'h01);
    chk(8'(txEdges), 8'h08);
    i_host.cyc(1'b0, 1'b0, 2'h2, 8'h00, d);
    chk(d, `BLC_RES_OK);
    chk({7'h0, reqToSendN}, 8'h01);
    chk({7'h0, sendServiceIrq}, 8'h00);
  endtask : t_send
  task automatic t_recv();
    rcv = 0;
    i_host.issue(8'h01, 0, 8'h00);
    carrierPresentIn = 1'b0;
    {seen, rxReq} = 2'b00;
    q = {1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    repeat (160) @(negedge ref_clk);
    chk({7'h0, seen}, 8'h00);
    carrierPresentIn = 1'b1;
    // Opening flag, one zero byte, closing flag
    q = {1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
         1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    repeat (440) @(negedge ref_clk);
    chk({7'h0, seen}, 8'h01);
    chk({7'h0, rxReq}, 8'h01);
    i_host.finish(st, res);
    chk(res, `BLC_RES_OK);
    chk({7'h0, recvServiceIrq}, 8'h01);
    i_host.cyc(1'b0, 1'b0, 2'h3, 8'h00, d);
    chk(d, 8'h01);
    chk({7'h0, rcv != 0}, 8'h01);
  endtask : t_recv
  initial begin
    {fails, num_checks, cycles, rcv} = '0;
    {clearToSend, carrierPresentIn, seen, rxReq, gpInputs} = '0;
    // Line idles high, matching the decoder's reset history, so no false first bit
    recvData = 1'b1;
    sys_rst = 1'b1;
    // Reset is asynchronous, so the link domain clears without its own edges
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    t_ports();
    t_phases();
    t_send();
    t_recv();
    tally_and_finish();
  end
endmodule : bit_oriented_link_ctrl_host_port_tb

//--- tb/blc_host_model.sv
// Host processor model: strobed register bus plus transmit DMA writes.
// Assumes ref_clk from the bench; changes its pins only at the falling edge.
`timescale 1ns/10ps
`include "blc_consts.svh"
module blc_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] dataOut,
  output logic            chipSelN,
  output logic            readN,
  output logic            writeN,
  output logic            sendDmaGrantN,
  output logic            recvDmaGrantN,
  output logic      [1:0] regSelect,
  output logic      [7:0] dataIn
);
  initial begin
    {chipSelN, readN, writeN, sendDmaGrantN, recvDmaGrantN} = 5'h1f;
    regSelect = 2'h0;
    dataIn = 8'h00;
  end
  // Strobes held 8 cycles low and high: the pin synchronisers need 4
  task automatic cyc(input logic wr, input logic dma, input logic [1:0] sel,
                     input logic [7:0] wd, output logic [7:0] rd);
    @(negedge ref_clk);
    regSelect = sel;
    dataIn = wd;
    chipSelN = dma;
    sendDmaGrantN = ~dma;
    writeN = ~wr;
    readN = wr;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rd = dataOut;
    {chipSelN, readN, writeN, sendDmaGrantN} = 4'hf;
    dataIn = ~wd;  // Released bus shows no stale byte
    repeat (8) @(negedge ref_clk);
  endtask : cyc
  task automatic issue(input logic [7:0] code, input int n, input logic [7:0] p);
    logic [7:0] d;
    cyc(1'b1, 1'b0, 2'h0, code, d);
    repeat (n) cyc(1'b1, 1'b0, 2'h1, p, d);
  endtask : issue
  task automatic finish(output logic [7:0] st, output logic [7:0] res);
    st = 8'h00;
    for (int i = 0; i < 400 && st[`BLC_ST_RESULT] !== 1'b1; i++) begin
      cyc(1'b0, 1'b0, 2'h0, 8'h00, st);
    end
    cyc(1'b0, 1'b0, 2'h1, 8'h00, res);
  endtask : finish
endmodule : blc_host_model
